/* mrsc_pkg.sv */
// mrsc_pkg: constants shared by the mode-register programming controller.
// assumes a single 20 MHz clock domain and a 32-bit plain software port.
package mrsc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int MA_W   = 14;
  localparam int TW     = 16;

  // software register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_DATA = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CFG  = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'hc;

  // control register fields
  localparam int CTRL_GO      = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_SLOW    = 4;
  localparam int CTRL_ODT     = 5;
  localparam int CTRL_CKE     = 6;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // configuration register fields
  localparam int CFG_CL_LSB  = 0;
  localparam int CL_W        = 6;
  localparam int CFG_WR_LSB  = 8;
  localparam int CFG_RTP_LSB = 12;

  // status register fields
  localparam int STAT_BUSY    = 0;
  localparam int STAT_MOD     = 1;
  localparam int STAT_DLL     = 2;
  localparam int STAT_ERR_LSB = 4;
  localparam int STAT_WR_LSB  = 16;

  // sticky refusal causes
  localparam int ERR_W    = 5;
  localparam int ERR_SEL  = 0;
  localparam int ERR_TEST = 1;
  localparam int ERR_AL   = 2;
  localparam int ERR_WR   = 3;
  localparam int ERR_BUSY = 4;

  // register selects, driven as {bg0, ba1, ba0}
  localparam logic [2:0] MR_ZERO = 3'h0;
  localparam logic [2:0] MR_ONE  = 3'h1;
  localparam logic [2:0] MR_RSVD = 3'h7;
  localparam int         NUM_MR  = 7;

  // mode_register_zero fields
  localparam int MR0_TEST_BIT = 7;
  localparam int MR0_DLL_BIT  = 8;
  localparam int MR0_WR_LSB   = 9;
  localparam int WR_W         = 3;
  localparam logic [MA_W-1:0] MR0_MASK = 14'h0fff;
  localparam logic [MA_W-1:0] MRX_MASK = 14'h3fff;

  // additive_latency field of register one
  localparam int         MR1_AL_LSB     = 3;
  localparam logic [1:0] AL_CL_MINUS_1  = 2'h1;
  localparam logic [CL_W-1:0] CL_NO_AL1 = 6'h18;

  localparam logic [TW-1:0] SINCE_MAX = 16'hffff;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE  = 2'b01,
    ST_HOLD = 2'b10
  } mrsc_state_e;

  // address bits that exist in the selected register; the rest go out as zero
  function automatic logic [MA_W-1:0] mr_mask(input logic [2:0] sel);
    if (sel == MR_ZERO) begin
      return MR0_MASK;
    end
    return MRX_MASK;
  endfunction

endpackage

/* mrsc_wait_timer.sv */
// mrsc_wait_timer: loadable down-counter, done while the count is zero.
// assumes load is a single-cycle request on the same clock.
`timescale 1ns/100ps
module mrsc_wait_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0);
endmodule

/* mrsc_ctrl.sv */
// mrsc_ctrl: issues mode set commands to a DDR4 device from software orders.
// assumes idle_ok comes from the command scheduler on this clock.
// What this block does
// - software writes every register after reset
// - every address field driven on each write
// - mode set commands spaced by cycle time
// - input-changing writes wait for function update
// - other commands wait mode-set-to-other delay
// - mode set only while device idle, cke high
// - odt low around termination-affecting mode sets
// - unused address bits driven zero
// - no additive CL-1 when column latency >=24
// - test mode bit seven kept zero
// - write recovery setting at least minimum
// - read-to-precharge setting at least minimum
// - dll reset self-clears, then wait lock time
// - register zero selected with selects low
`timescale 1ns/100ps
module mrsc_ctrl #(
  parameter int MRD_CYC  = 8,
  parameter int MOD_CYC  = 24,
  parameter int UPD_CYC  = 64,
  parameter int DLLK_CYC = 1024
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic [mrsc_pkg::ADDR_W-1:0]   addr,
  input  wire logic [mrsc_pkg::DATA_W-1:0]   wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [mrsc_pkg::DATA_W-1:0]   rdata,
  input  wire logic                          idle_ok,
  output logic                               mem_cke,
  output logic                               mem_cs_n,
  output logic                               mem_act_n,
  output logic                               mem_ras_n,
  output logic                               mem_cas_n,
  output logic                               mem_we_n,
  output logic      [1:0]                    mem_bg,
  output logic      [1:0]                    mem_ba,
  output logic      [mrsc_pkg::MA_W-1:0]     mem_a,
  output logic                               mem_odt,
  output logic                               other_cmd_ok,
  output logic                               dll_ready
);
  mrsc_pkg::mrsc_state_e state_q, state_d;
  logic [2:0]                  sel_q, sel_d;
  logic                        slow_q, slow_d;
  logic                        odt_req_q, odt_req_d;
  logic                        cke_q, cke_d;
  logic [mrsc_pkg::MA_W-1:0]   data_q, data_d;
  logic [mrsc_pkg::CL_W-1:0]   cl_q, cl_d;
  logic [mrsc_pkg::WR_W-1:0]   min_wr_q, min_wr_d;
  logic [mrsc_pkg::WR_W-1:0]   min_rtp_q, min_rtp_d;
  logic [mrsc_pkg::ERR_W-1:0]  err_q, err_d;
  logic [mrsc_pkg::NUM_MR-1:0] written_q, written_d;
  logic [mrsc_pkg::DATA_W-1:0] rdata_d;
  logic                        mrs_q, mrs_d;
  logic                        cmd_n_q, cmd_n_d;
  logic                        act_n_q, act_n_d;
  logic                        odt_q, odt_d;
  logic [1:0]                  bg_q, bg_d;
  logic [1:0]                  ba_q, ba_d;
  logic [mrsc_pkg::MA_W-1:0]   a_q, a_d;
  logic                        mod_ok_q, mod_ok_d;
  logic                        dll_ok_q, dll_ok_d;
  logic                        go, issue, dll_issue;
  logic [mrsc_pkg::ERR_W-1:0]  refuse;
  logic                        space_done, mod_done, dll_done;
  logic [mrsc_pkg::TW-1:0]     space_len, mod_len;

  assign go = wr && (addr == mrsc_pkg::REG_CTRL) && wdata[mrsc_pkg::CTRL_GO];

  // checks made when software asks for a write
  always_comb begin
    refuse = '0;
    if (state_q != mrsc_pkg::ST_IDLE) begin
      refuse[mrsc_pkg::ERR_BUSY] = 1'b1;
    end
    if (wdata[mrsc_pkg::CTRL_SEL_LSB +: 3] == mrsc_pkg::MR_RSVD) begin
      refuse[mrsc_pkg::ERR_SEL] = 1'b1;
    end
    if (wdata[mrsc_pkg::CTRL_SEL_LSB +: 3] == mrsc_pkg::MR_ZERO) begin
      if (data_q[mrsc_pkg::MR0_TEST_BIT]) begin
        refuse[mrsc_pkg::ERR_TEST] = 1'b1;
      end
      if (data_q[mrsc_pkg::MR0_WR_LSB +: mrsc_pkg::WR_W] < min_wr_q ||
          data_q[mrsc_pkg::MR0_WR_LSB +: mrsc_pkg::WR_W] < min_rtp_q) begin
        refuse[mrsc_pkg::ERR_WR] = 1'b1;
      end
    end
    if (wdata[mrsc_pkg::CTRL_SEL_LSB +: 3] == mrsc_pkg::MR_ONE && cl_q >= mrsc_pkg::CL_NO_AL1 &&
        data_q[mrsc_pkg::MR1_AL_LSB +: 2] == mrsc_pkg::AL_CL_MINUS_1) begin
      refuse[mrsc_pkg::ERR_AL] = 1'b1;
    end
  end

  // issue needs odt already registered low and an idle device with cke high
  assign issue     = (state_q == mrsc_pkg::ST_PRE) && !odt_q && idle_ok && cke_q;
  assign dll_issue = issue && (sel_q == mrsc_pkg::MR_ZERO) && data_q[mrsc_pkg::MR0_DLL_BIT];
  // writes that change input handling get the longer update wait
  assign space_len = slow_q ? mrsc_pkg::TW'(UPD_CYC - 1) : mrsc_pkg::TW'(MRD_CYC - 1);
  assign mod_len   = slow_q ? mrsc_pkg::TW'(UPD_CYC - 1) : mrsc_pkg::TW'(MOD_CYC - 1);

  mrsc_wait_timer #(.W(mrsc_pkg::TW)) u_space (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (issue),
    .load_val (space_len),
    .done     (space_done)
  );

  mrsc_wait_timer #(.W(mrsc_pkg::TW)) u_mod (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (issue),
    .load_val (mod_len),
    .done     (mod_done)
  );

  mrsc_wait_timer #(.W(mrsc_pkg::TW)) u_dll (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (dll_issue),
    .load_val (mrsc_pkg::TW'(DLLK_CYC - 1)),
    .done     (dll_done)
  );

  always_comb begin
    state_d   = state_q;
    sel_d     = sel_q;
    slow_d    = slow_q;
    odt_req_d = odt_req_q;
    cke_d     = cke_q;
    data_d    = data_q;
    cl_d      = cl_q;
    min_wr_d  = min_wr_q;
    min_rtp_d = min_rtp_q;
    err_d     = err_q;
    written_d = written_q;
    rdata_d   = '0;
    if (wr) begin
      if (addr == mrsc_pkg::REG_CTRL) begin
        odt_req_d = wdata[mrsc_pkg::CTRL_ODT];
        cke_d     = wdata[mrsc_pkg::CTRL_CKE];
        if (state_q == mrsc_pkg::ST_IDLE) begin
          sel_d  = wdata[mrsc_pkg::CTRL_SEL_LSB +: 3];
          slow_d = wdata[mrsc_pkg::CTRL_SLOW];
        end
      end else if (addr == mrsc_pkg::REG_DATA) begin
        data_d = wdata[mrsc_pkg::MA_W-1:0];
      end else if (addr == mrsc_pkg::REG_CFG) begin
        cl_d      = wdata[mrsc_pkg::CFG_CL_LSB +: mrsc_pkg::CL_W];
        min_wr_d  = wdata[mrsc_pkg::CFG_WR_LSB +: mrsc_pkg::WR_W];
        min_rtp_d = wdata[mrsc_pkg::CFG_RTP_LSB +: mrsc_pkg::WR_W];
      end else if (addr == mrsc_pkg::REG_STAT) begin
        err_d = err_q & ~wdata[mrsc_pkg::STAT_ERR_LSB +: mrsc_pkg::ERR_W];
      end
    end
    // a refusal in the clearing cycle still sticks
    if (go) begin
      err_d = err_d | refuse;
    end
    if (rd) begin
      if (addr == mrsc_pkg::REG_CTRL) begin
        rdata_d[mrsc_pkg::CTRL_SEL_LSB +: 3] = sel_q;
        rdata_d[mrsc_pkg::CTRL_SLOW]         = slow_q;
        rdata_d[mrsc_pkg::CTRL_ODT]          = odt_req_q;
        rdata_d[mrsc_pkg::CTRL_CKE]          = cke_q;
      end else if (addr == mrsc_pkg::REG_DATA) begin
        rdata_d[mrsc_pkg::MA_W-1:0] = data_q;
      end else if (addr == mrsc_pkg::REG_CFG) begin
        rdata_d[mrsc_pkg::CFG_CL_LSB +: mrsc_pkg::CL_W]  = cl_q;
        rdata_d[mrsc_pkg::CFG_WR_LSB +: mrsc_pkg::WR_W]  = min_wr_q;
        rdata_d[mrsc_pkg::CFG_RTP_LSB +: mrsc_pkg::WR_W] = min_rtp_q;
      end else if (addr == mrsc_pkg::REG_STAT) begin
        rdata_d[mrsc_pkg::STAT_BUSY]                       = (state_q != mrsc_pkg::ST_IDLE);
        rdata_d[mrsc_pkg::STAT_MOD]                        = mod_ok_q;
        rdata_d[mrsc_pkg::STAT_DLL]                        = dll_ok_q;
        rdata_d[mrsc_pkg::STAT_ERR_LSB +: mrsc_pkg::ERR_W] = err_q;
        rdata_d[mrsc_pkg::STAT_WR_LSB +: mrsc_pkg::NUM_MR] = written_q;
      end
    end
    case (state_q)
      mrsc_pkg::ST_IDLE: begin
        if (go && refuse == '0) begin
          state_d = mrsc_pkg::ST_PRE;
        end
      end
      mrsc_pkg::ST_PRE: begin
        if (issue) begin
          state_d                    = mrsc_pkg::ST_HOLD;
          written_d[sel_q[2:0]]      = 1'b1;
        end
      end
      mrsc_pkg::ST_HOLD: begin
        if (space_done) begin
          state_d = mrsc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = mrsc_pkg::ST_IDLE;
      end
    endcase
  end

  // pin values: one-cycle mode set, deselect otherwise
  always_comb begin
    mrs_d    = issue;
    // active-low copy kept as its own flop so the pins leave straight from registers
    cmd_n_d  = ~issue;
    act_n_d  = 1'b1;
    bg_d     = bg_q;
    ba_d     = ba_q;
    a_d      = a_q;
    if (issue) begin
      bg_d = {1'b0, sel_q[2]};
      ba_d = sel_q[1:0];
      a_d  = data_q & mrsc_pkg::mr_mask(sel_q);
    end
    // odt stays low from request until the other-command delay has run out
    odt_d    = odt_req_q && (state_q == mrsc_pkg::ST_IDLE) && !(go && refuse == '0) && mod_done && !mrs_q;
    mod_ok_d = mod_done && !issue && !mrs_q;
    dll_ok_d = dll_done && !dll_issue;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= mrsc_pkg::ST_IDLE;
      sel_q     <= mrsc_pkg::MR_ZERO;
      slow_q    <= 1'b0;
      odt_req_q <= 1'b0;
      cke_q     <= 1'b0;
      data_q    <= '0;
      cl_q      <= '0;
      min_wr_q  <= '0;
      min_rtp_q <= '0;
      err_q     <= '0;
      written_q <= '0;
      rdata     <= '0;
    end else if (ce) begin
      state_q   <= state_d;
      sel_q     <= sel_d;
      slow_q    <= slow_d;
      odt_req_q <= odt_req_d;
      cke_q     <= cke_d;
      data_q    <= data_d;
      cl_q      <= cl_d;
      min_wr_q  <= min_wr_d;
      min_rtp_q <= min_rtp_d;
      err_q     <= err_d;
      written_q <= written_d;
      rdata     <= rdata_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mrs_q    <= 1'b0;
      cmd_n_q  <= 1'b1;
      act_n_q  <= 1'b1;
      odt_q    <= 1'b0;
      bg_q     <= '0;
      ba_q     <= '0;
      a_q      <= '0;
      mod_ok_q <= 1'b0;
      dll_ok_q <= 1'b0;
    end else if (ce) begin
      mrs_q    <= mrs_d;
      cmd_n_q  <= cmd_n_d;
      act_n_q  <= act_n_d;
      odt_q    <= odt_d;
      bg_q     <= bg_d;
      ba_q     <= ba_d;
      a_q      <= a_d;
      mod_ok_q <= mod_ok_d;
      dll_ok_q <= dll_ok_d;
    end
  end

  assign mem_cs_n     = cmd_n_q;
  assign mem_act_n    = act_n_q;
  assign mem_ras_n    = cmd_n_q;
  assign mem_cas_n    = cmd_n_q;
  assign mem_we_n     = cmd_n_q;
  assign mem_bg       = bg_q;
  assign mem_ba       = ba_q;
  assign mem_a        = a_q;
  assign mem_odt      = odt_q;
  assign mem_cke      = cke_q;
  assign other_cmd_ok = mod_ok_q;
  assign dll_ready    = dll_ok_q;

  // helper for the checks: edges since the last mode set
  logic [mrsc_pkg::TW-1:0] since_q, since_d;
  always_comb begin
    since_d = since_q;
    if (mrs_q) begin
      since_d = mrsc_pkg::TW'(1);
    end else if (since_q != mrsc_pkg::SINCE_MAX) begin
      since_d = since_q + mrsc_pkg::TW'(1);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_q <= mrsc_pkg::SINCE_MAX;
    end else if (ce) begin
      since_q <= since_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  property p_mrs_encoding;
    !mem_cs_n |-> !mem_ras_n && !mem_cas_n && !mem_we_n && mem_act_n;
  endproperty
  a_mrs_encoding: assert property (p_mrs_encoding) else $error("bad mode set encoding");
  property p_spacing;
    !mem_cs_n |-> since_q >= MRD_CYC;
  endproperty
  a_spacing: assert property (p_spacing) else $error("mode sets too close");
  property p_mod_wait;
    $rose(other_cmd_ok) |-> since_q >= MOD_CYC;
  endproperty
  a_mod_wait: assert property (p_mod_wait) else $error("other command allowed too early");
  property p_mod_drop;
    !mem_cs_n |=> !other_cmd_ok;
  endproperty
  a_mod_drop: assert property (p_mod_drop) else $error("other command allowed after mode set");
  property p_idle_cke;
    !mem_cs_n |-> mem_cke && $past(idle_ok);
  endproperty
  a_idle_cke: assert property (p_idle_cke) else $error("mode set while not idle");
  property p_odt_low;
    !mem_cs_n |-> !mem_odt && $past(!mem_odt) ##1 !mem_odt;
  endproperty
  a_odt_low: assert property (p_odt_low) else $error("odt high around mode set");
  property p_no_rsvd;
    !mem_cs_n |-> !(mem_bg[0] && mem_ba == 2'h3);
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved select issued");
  property p_unused_zero;
    !mem_cs_n |-> (mem_a & ~mrsc_pkg::mr_mask({mem_bg[0], mem_ba})) == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused address bit high");
  property p_no_test;
    !mem_cs_n && {mem_bg, mem_ba} == 4'h0 |-> !mem_a[mrsc_pkg::MR0_TEST_BIT];
  endproperty
  a_no_test: assert property (p_no_test) else $error("test mode written");
  property p_dll_wait;
    !mem_cs_n && {mem_bg, mem_ba} == 4'h0 && mem_a[mrsc_pkg::MR0_DLL_BIT] |-> !dll_ready [*2];
  endproperty
  a_dll_wait: assert property (p_dll_wait) else $error("dll ready too soon");

  c_mr0: cover property (!mem_cs_n && {mem_bg, mem_ba} == 4'h0);
  c_refused: cover property (go && refuse != '0);
  c_dll_done: cover property ($rose(dll_ready));
  c_back_to_back: cover property (!mem_cs_n ##[1:80] !mem_cs_n);
endmodule

/* mrsc_dev_model.sv */
// mrsc_dev_model: behavioural device face that takes mode set commands.
// assumes the controller drives every command pin from flops on clk.
`timescale 1ns/100ps
module mrsc_dev_model #(
  parameter int MRD_CYC = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        act_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  bg,
  input  wire logic [1:0]  ba,
  input  wire logic [13:0] a,
  input  wire logic        odt,
  output logic      [13:0] mr0,
  output logic             burst_il,
  output logic      [1:0]  burst_len,
  output logic      [7:0]  n_ms,
  output logic      [7:0]  n_viol
);
  logic [13:0] mr_q [0:6];
  logic [2:0]  sel;
  logic        ms;
  logic        bad;
  int          since;

  assign sel       = {bg[0], ba};
  assign ms        = cke && !cs_n && act_n && !ras_n && !cas_n && !we_n;
  assign mr0       = mr_q[0];
  // beat order and chop timing follow from these fields
  assign burst_il  = mr_q[0][3];
  assign burst_len = mr_q[0][1:0];
  // spacing, odt level and mr0 spare or test bits are counted as misuse
  assign bad = (since < MRD_CYC - 1) || odt || (sel == 3'h0 && (a[13:12] != 2'h0 || a[7]));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      n_ms   <= 8'h00;
      n_viol <= 8'h00;
      since  <= 1000;
      for (int i = 0; i < 7; i++) begin
        mr_q[i] <= 14'h0000;
      end
    end else begin
      since <= since + 1;
      if (ms && sel != 3'h7) begin
        if (bad) begin
          n_viol <= n_viol + 8'h01;
        end
        // array contents are not modelled, so a mode set cannot touch them
        mr_q[sel] <= (sel == 3'h0) ? (a & 14'h3eff) : a;
        n_ms      <= n_ms + 8'h01;
        since     <= 0;
      end
    end
  end
endmodule

/* tb.sv */
// tb: self-checking bench for mrsc_ctrl with the device model on its pins.
// assumes mrsc_pkg and mrsc_dev_model are compiled first.
`timescale 1ns/100ps
module tb;
  localparam int MOD  = 24;
  localparam int DLLK = 16;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        ce      = 1'b1;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        idle_ok = 1'b1;
  logic [3:0]  addr    = 4'h0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [31:0] cb      = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic        cke, cs_n, act_n, ras_n, cas_n, we_n, odt, ocok, dllr, bil;
  logic [1:0]  bg, ba, bl;
  logic [13:0] a, mr0;
  logic [7:0]  n_ms, n_viol;
  int          failures        = 0;
  int          samples_checked = 0;

  always #25 clk = ~clk;

  mrsc_ctrl #(.MRD_CYC(8), .MOD_CYC(MOD), .UPD_CYC(64), .DLLK_CYC(DLLK)) i_dut (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .idle_ok(idle_ok), .mem_cke(cke), .mem_cs_n(cs_n), .mem_act_n(act_n),
    .mem_ras_n(ras_n), .mem_cas_n(cas_n), .mem_we_n(we_n), .mem_bg(bg), .mem_ba(ba),
    .mem_a(a), .mem_odt(odt), .other_cmd_ok(ocok), .dll_ready(dllr));

  mrsc_dev_model #(.MRD_CYC(8)) i_dev (
    .clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .a(a), .odt(odt), .mr0(mr0),
    .burst_il(bil), .burst_len(bl), .n_ms(n_ms), .n_viol(n_viol));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wreg(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr  <= ad;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] ad);
    @(posedge clk);
    addr <= ad;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic go(input logic [2:0] s);
    wreg(mrsc_pkg::REG_CTRL, cb | 32'h0000_0001 | (32'(s) << 1));
  endtask

  task automatic mrs(input logic [2:0] s, input logic [13:0] d);
    wreg(mrsc_pkg::REG_DATA, 32'(d));
    go(s);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 40; i++) begin
      rreg(mrsc_pkg::REG_STAT);
      if (rv[0] === 1'b0) break;
    end
    chk(rv[0], 1'b0);
  endtask

  // returns just after the edge that put the command on the pins
  task automatic wait_issue();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      if (cs_n === 1'b0) break;
    end
    chk(i < 20, 1'b1);
  endtask

  task automatic t_reset();
    rreg(mrsc_pkg::REG_STAT);
    chk(rv, 32'h0000_0006);
    chk({cs_n, cke, odt}, 3'b100);
  endtask

  task automatic t_setup();
    wreg(mrsc_pkg::REG_CFG, 32'h0000_2218);
    rreg(mrsc_pkg::REG_CFG);
    chk(rv, 32'h0000_2218);
    cb = 32'h0000_0060;
    wreg(mrsc_pkg::REG_CTRL, cb);
    repeat (3) @(posedge clk);
    #1 chk({cke, odt}, 2'b11);
  endtask

  task automatic t_mr0();
    mrs(3'h0, 14'h3904);
    wait_issue();
    chk({bg, ba, a, ras_n, cas_n, we_n, act_n, odt}, {4'h0, 14'h0904, 4'b0001, 1'b0});
    repeat (2) @(posedge clk);
    #1 chk({cs_n, ocok, dllr}, 3'b100);
    repeat (11) @(posedge clk);
    #1 chk(dllr, 1'b0);
    repeat (6) @(posedge clk);
    #1 chk({dllr, ocok}, 2'b10);
    repeat (8) @(posedge clk);
    #1 chk({ocok, odt}, 2'b11);
    chk({mr0, bil, bl}, {14'h0804, 3'b000});
  endtask

  task automatic t_refuse();
    logic [2:0]  s [4] = '{3'h7, 3'h0, 3'h1, 3'h0};
    logic [13:0] d [4] = '{14'h0000, 14'h0480, 14'h0008, 14'h0200};
    logic [4:0]  e [4] = '{5'h01, 5'h02, 5'h04, 5'h08};
    logic [7:0]  nm;
    nm = n_ms;
    for (int i = 0; i < 4; i++) begin
      mrs(s[i], d[i]);
      repeat (4) @(posedge clk);
      rreg(mrsc_pkg::REG_STAT);
      chk(rv[8:4], e[i]);
      wreg(mrsc_pkg::REG_STAT, {23'h0, e[i], 4'h0});
      rreg(mrsc_pkg::REG_STAT);
      chk(rv[8:4], 5'h00);
    end
    chk(n_ms, nm);
  endtask

  // slow mode: spacing and other-command delay both stretch to the update wait
  task automatic t_slow();
    wait_idle();
    wreg(mrsc_pkg::REG_DATA, 32'h0000_0000);
    wreg(mrsc_pkg::REG_CTRL, cb | 32'h0000_0015);
    wait_issue();
    repeat (30) @(posedge clk);
    rreg(mrsc_pkg::REG_STAT);
    chk(rv[2:0], 3'b101);
    repeat (40) @(posedge clk);
    rreg(mrsc_pkg::REG_STAT);
    chk(rv[2:0], 3'b110);
  endtask

  task automatic t_burst();
    logic [7:0] nm;
    nm = n_ms;
    for (int i = 0; i < 7; i++) begin
      wait_idle();
      if (i == 2) begin
        @(posedge clk);
        idle_ok <= 1'b0;
      end
      mrs(3'(i), 14'h0400 | 14'(i << 11));
      if (i == 2) begin
        repeat (10) @(posedge clk);
        #1 chk(n_ms, nm + 8'h02);
        @(posedge clk);
        idle_ok <= 1'b1;
      end
    end
    go(3'h1);
    wait_idle();
    rreg(mrsc_pkg::REG_STAT);
    chk({rv[22:16], rv[8:4]}, {7'h7f, 5'h10});
    chk(n_ms, nm + 8'h07);
    chk(n_viol, 8'h00);
  endtask

  task automatic tally_and_finish();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_setup();
    t_mr0();
    t_refuse();
    t_slow();
    t_burst();
    tally_and_finish();
  end

  // whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
